// file: logic/aadc_consts.vh
// Purpose: constants of the address detection controller
// Assumes: byte addresses on a 32-bit AXI4-Lite register bus
// Notes:   times are in milliseconds, counts derive from the clock rate
`ifndef AADC_CONSTS_VH
`define AADC_CONSTS_VH

`define AADC_CLK_HZ        125000000
`define AADC_CYC_PER_MS    (`AADC_CLK_HZ / 1000)
`define AADC_STARTUP_MS    5000
`define AADC_STORE_MS      1000
`define AADC_SETTLE_MS     500
`define AADC_LONGPRESS_MS  2000

// register byte offsets
`define AADC_RX0_OFS       12'h000
`define AADC_RX1_OFS       12'h004
`define AADC_RX2_OFS       12'h008
`define AADC_RY0_OFS       12'h00c
`define AADC_RY1_OFS       12'h010
`define AADC_RY2_OFS       12'h014
`define AADC_FAULT_ID_OFS  12'h018
`define AADC_ID_COUNT_OFS  12'h01c
`define AADC_IN_BASE       12'h040
`define AADC_OUT_BASE      12'h080
`define AADC_LIST_BASE     12'h200

// first remote input word
`define AADC_RX0_READY     0
`define AADC_RX0_SHORT     1
`define AADC_RX0_VDROP     3
`define AADC_RX0_DISC      4
`define AADC_RX0_OVER      6
`define AADC_RX0_PACC      10
`define AADC_RX0_PACCING   11
`define AADC_RX0_ADJUST    15
// second remote input word
`define AADC_RX1_ALARM     0
`define AADC_RX1_PDONE     1
`define AADC_RX1_PERR      2
`define AADC_RX1_DETECT    4
// remote output words
`define AADC_RY0_ERRCLR    0
`define AADC_RY0_DETCMD    1

// error codes that block detection
`define AADC_ERR_HW_LO     16'h0064
`define AADC_ERR_HW_HI     16'h0067
`define AADC_ERR_VDROP     16'h00c8
`define AADC_ERR_SHORT     16'h00c9

`define AADC_ID_LAST       16'h02fe
`define AADC_MAX_SLAVES    128

`endif

// file: logic/aadc_top.v
// Purpose: address detection control of a network to field bus bridge
// Assumes: all inputs synchronous to aclk; field side probes one id per handshake
// Notes:   remote bit words and detection results are reached over AXI4-Lite
`timescale 1ns/1ps
`default_nettype none
`include "aadc_consts.vh"

module aadc_top #(
  parameter [31:0] STARTUP_CYC = `AADC_STARTUP_MS * `AADC_CYC_PER_MS,
  parameter [31:0] STORE_CYC   = `AADC_STORE_MS * `AADC_CYC_PER_MS,
  parameter [31:0] SETTLE_CYC  = `AADC_SETTLE_MS * `AADC_CYC_PER_MS,
  parameter [31:0] PRESS_CYC   = `AADC_LONGPRESS_MS * `AADC_CYC_PER_MS,
  parameter [15:0] ID_LAST     = `AADC_ID_LAST,
  parameter [7:0]  MAX_SLAVES  = `AADC_MAX_SLAVES
) (
  input  wire         aclk,
  input  wire         aresetn,
  input  wire [11:0]  s_axi_awaddr,
  input  wire [2:0]   s_axi_awprot,
  input  wire         s_axi_awvalid,
  output reg          s_axi_awready,
  input  wire [31:0]  s_axi_wdata,
  input  wire [3:0]   s_axi_wstrb,
  input  wire         s_axi_wvalid,
  output reg          s_axi_wready,
  output reg  [1:0]   s_axi_bresp,
  output reg          s_axi_bvalid,
  input  wire         s_axi_bready,
  input  wire [11:0]  s_axi_araddr,
  input  wire [2:0]   s_axi_arprot,
  input  wire         s_axi_arvalid,
  output reg          s_axi_arready,
  output reg  [31:0]  s_axi_rdata,
  output reg  [1:0]   s_axi_rresp,
  output reg          s_axi_rvalid,
  input  wire         s_axi_rready,
  input  wire         push_switch,
  input  wire         field_short,
  input  wire         field_vdrop,
  input  wire         field_disc,
  input  wire [15:0]  error_code,
  input  wire         adjust_active_flag,
  input  wire         param_access_flag,
  input  wire         param_accessing_flag,
  input  wire         param_done,
  input  wire         param_err_event,
  input  wire         bank_indication,
  input  wire         bank_switching,
  input  wire [255:0] field_in,
  output reg  [255:0] field_out,
  output reg  [2:0]   param_cmd,
  output reg  [1:0]   bank_cmd,
  output reg          store_indicator,
  output reg          probe_req,
  output reg  [15:0]  probe_id,
  input  wire         probe_ack,
  input  wire         probe_found,
  input  wire         probe_no_id,
  input  wire         probe_dup
);

  localparam [2:0] S_IDLE   = 3'd0;
  localparam [2:0] S_STORE  = 3'd1;
  localparam [2:0] S_SETTLE = 3'd2;
  localparam [2:0] S_PROBE  = 3'd3;
  localparam [2:0] S_WAIT   = 3'd4;

  function [31:0] apply_strb;
    input [31:0] old_val;
    input [31:0] new_val;
    input [3:0]  strb;
    integer      i;
    begin
      apply_strb = old_val;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i])
          apply_strb[i*8 +: 8] = new_val[i*8 +: 8];
      end
    end
  endfunction

  function code_blocks;
    input [15:0] code;
    begin
      code_blocks = ((code >= `AADC_ERR_HW_LO) && (code <= `AADC_ERR_HW_HI)) ||
                    (code == `AADC_ERR_VDROP) || (code == `AADC_ERR_SHORT);
    end
  endfunction

  reg  [2:0]   state;
  reg  [31:0]  timer;
  reg  [31:0]  startup_cnt;
  reg          startup_done;
  reg  [31:0]  press_cnt;
  reg          press_fire;
  reg  [15:0]  ry0;
  reg          detcmd_q;
  reg          detect_flag;
  reg          ready_flag;
  reg          short_flag;
  reg          vdrop_flag;
  reg          disc_flag;
  reg          over_flag;
  reg          alarm_flag;
  reg          perr_flag;
  reg  [15:0]  latest_fault_id_word;
  reg  [15:0]  connected_id_count_word;
  reg  [15:0]  id_list [0:127];
  reg  [255:0] in_snap;
  reg  [255:0] out_words;
  reg  [11:0]  aw_addr;
  reg          aw_have;
  reg  [31:0]  w_data;
  reg  [3:0]   w_strb;
  reg          w_have;

  wire error_clear_request = ry0[`AADC_RY0_ERRCLR];
  wire detect_command_bit  = ry0[`AADC_RY0_DETCMD];
  wire link_fault = field_short | field_vdrop | field_disc;

  // command taken on its rising edge
  wire cmd_edge = detect_command_bit & ~detcmd_q;
  // long press counts as a request
  wire request = cmd_edge | press_fire;
  wire accept = request & startup_done & ~link_fault & ~adjust_active_flag &
                ~code_blocks(error_code) & param_done & ~detect_flag;

  wire probe_done = (state == S_WAIT) & probe_ack;
  wire bad_id     = probe_done & probe_found & (probe_no_id | probe_dup);
  wire good_id    = probe_done & probe_found & ~probe_no_id & ~probe_dup;
  wire list_full  = connected_id_count_word >= {8'h00, MAX_SLAVES};
  wire last_id    = probe_id == ID_LAST;

  always @(posedge aclk) begin
    if (!aresetn) begin
      startup_cnt  <= 32'h0000_0000;
      startup_done <= 1'b0;
    end else if (!startup_done) begin
      if (startup_cnt >= STARTUP_CYC - 32'd1)
        startup_done <= 1'b1;
      else
        startup_cnt <= startup_cnt + 32'd1;
    end
  end

  // one shot after switch held long enough
  always @(posedge aclk) begin
    if (!aresetn) begin
      press_cnt  <= 32'h0000_0000;
      press_fire <= 1'b0;
    end else begin
      press_fire <= 1'b0;
      if (!push_switch) begin
        press_cnt <= 32'h0000_0000;
      end else if (press_cnt < PRESS_CYC) begin
        press_cnt <= press_cnt + 32'd1;
        if (press_cnt == PRESS_CYC - 32'd1)
          press_fire <= 1'b1;
      end
    end
  end

  // detection sequence
  always @(posedge aclk) begin
    if (!aresetn) begin
      state                   <= S_IDLE;
      timer                   <= 32'h0000_0000;
      detect_flag             <= 1'b0;
      store_indicator         <= 1'b0;
      probe_req               <= 1'b0;
      probe_id                <= 16'h0000;
      connected_id_count_word <= 16'h0000;
      over_flag               <= 1'b0;
      detcmd_q                <= 1'b0;
    end else begin
      detcmd_q <= detect_command_bit;
      case (state)
        S_IDLE: begin
          if (accept) begin
            detect_flag             <= 1'b1;
            store_indicator         <= 1'b1;
            timer                   <= 32'h0000_0000;
            connected_id_count_word <= 16'h0000;
            over_flag               <= 1'b0;
            state                   <= S_STORE;
          end
        end
        S_STORE: begin
          if (timer >= STORE_CYC - 32'd1) begin
            store_indicator <= 1'b0;
            timer           <= 32'h0000_0000;
            state           <= S_SETTLE;
          end else begin
            timer <= timer + 32'd1;
          end
        end
        S_SETTLE: begin
          // wait after the indicator goes dark
          if (timer >= SETTLE_CYC - 32'd1) begin
            probe_id <= 16'h0000;
            state    <= S_PROBE;
          end else begin
            timer <= timer + 32'd1;
          end
        end
        S_PROBE: begin
          probe_req <= 1'b1;
          state     <= S_WAIT;
        end
        S_WAIT: begin
          if (probe_ack) begin
            probe_req <= 1'b0;
            // ascending ids, stop storing at the maximum
            if (good_id) begin
              if (!list_full)
                connected_id_count_word <= connected_id_count_word + 16'd1;
              else
                over_flag <= 1'b1;
            end
            if (last_id) begin
              detect_flag <= 1'b0;
              state       <= S_IDLE;
            end else begin
              probe_id <= probe_id + 16'd1;
              state    <= S_PROBE;
            end
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  always @(posedge aclk) begin
    if (good_id && !list_full)
      id_list[connected_id_count_word[6:0]] <= probe_id;
  end

  // sticky alarm and access error, set wins over clear
  always @(posedge aclk) begin
    if (!aresetn) begin
      alarm_flag           <= 1'b0;
      perr_flag            <= 1'b0;
      latest_fault_id_word <= 16'h0000;
      short_flag           <= 1'b0;
      vdrop_flag           <= 1'b0;
      disc_flag            <= 1'b0;
    end else begin
      if (bad_id) begin
        alarm_flag           <= 1'b1;
        latest_fault_id_word <= probe_id;
      end else if (error_clear_request) begin
        alarm_flag <= 1'b0;
      end
      if (param_err_event)
        perr_flag <= 1'b1;
      else if (error_clear_request)
        perr_flag <= 1'b0;
      if (field_short)
        short_flag <= 1'b1;
      else if (error_clear_request)
        short_flag <= 1'b0;
      if (field_vdrop)
        vdrop_flag <= 1'b1;
      else if (error_clear_request)
        vdrop_flag <= 1'b0;
      if (field_disc)
        disc_flag <= 1'b1;
      else if (error_clear_request)
        disc_flag <= 1'b0;
    end
  end

  // ready low on a latched or live fault, alarm, access error or blocking error code, and while clear request is high
  always @(posedge aclk) begin
    if (!aresetn)
      ready_flag <= 1'b0;
    else
      ready_flag <= ~(short_flag | vdrop_flag | disc_flag | alarm_flag | perr_flag |
                      link_fault | code_blocks(error_code) | error_clear_request);
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      in_snap   <= {256{1'b0}};
      field_out <= {256{1'b0}};
    end else if (!detect_flag) begin
      in_snap   <= field_in;
      field_out <= out_words;
    end
  end

  // AXI4-Lite write side
  wire       do_write = aw_have & w_have & ~s_axi_bvalid;
  wire [3:0] wword    = aw_addr[5:2];
  wire       w_in_out = aw_addr[11:6] == `AADC_OUT_BASE >> 6;
  wire       w_ry0    = aw_addr[11:2] == `AADC_RY0_OFS >> 2;
  wire       w_ry1    = aw_addr[11:2] == `AADC_RY1_OFS >> 2;
  wire       w_ry2    = aw_addr[11:2] == `AADC_RY2_OFS >> 2;
  wire [31:0] out_cur = {16'h0000, out_words[wword*16 +: 16]};
  wire [31:0] out_new = apply_strb(out_cur, w_data, w_strb);
  wire [31:0] ry0_new = apply_strb({16'h0000, ry0}, w_data, w_strb);
  wire [31:0] ry1_new = apply_strb({29'h0, param_cmd}, w_data, w_strb);
  wire [31:0] ry2_new = apply_strb({30'h0, bank_cmd}, w_data, w_strb);

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
      aw_have       <= 1'b0;
      w_have        <= 1'b0;
      aw_addr       <= 12'h000;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
      ry0           <= 16'h0000;
      param_cmd     <= 3'h0;
      bank_cmd      <= 2'h0;
      out_words     <= {256{1'b0}};
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr       <= s_axi_awaddr;
        aw_have       <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
        w_have       <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        aw_have      <= 1'b0;
        w_have       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= 2'b00;
        if (w_ry0)
          ry0 <= {14'h0000, ry0_new[1:0]};
        else if (w_ry1)
          param_cmd <= ry1_new[2:0];
        else if (w_ry2)
          bank_cmd <= ry2_new[1:0];
        else if (w_in_out && aw_addr[1:0] == 2'b00)
          out_words[wword*16 +: 16] <= out_new[15:0];
        else if (aw_addr[11:2] != `AADC_RX0_OFS >> 2 && aw_addr[11:2] != `AADC_RX1_OFS >> 2 &&
                 aw_addr[11:2] != `AADC_RX2_OFS >> 2)
          s_axi_bresp <= 2'b10;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // AXI4-Lite read side
  reg  [31:0] rd_val;
  reg         rd_ok;
  wire [3:0]  rword = s_axi_araddr[5:2];
  wire [6:0]  lidx  = s_axi_araddr[8:2];

  always @* begin
    rd_val = 32'h0000_0000;
    rd_ok  = 1'b1;
    case (s_axi_araddr[11:2])
      `AADC_RX0_OFS >> 2: begin
        rd_val[`AADC_RX0_READY]   = ready_flag;
        rd_val[`AADC_RX0_SHORT]   = short_flag;
        rd_val[`AADC_RX0_VDROP]   = vdrop_flag;
        rd_val[`AADC_RX0_DISC]    = disc_flag;
        rd_val[`AADC_RX0_OVER]    = over_flag;
        rd_val[`AADC_RX0_PACC]    = param_access_flag;
        rd_val[`AADC_RX0_PACCING] = param_accessing_flag;
        rd_val[`AADC_RX0_ADJUST]  = adjust_active_flag;
      end
      `AADC_RX1_OFS >> 2: begin
        rd_val[`AADC_RX1_ALARM]  = alarm_flag;
        rd_val[`AADC_RX1_PDONE]  = param_done;
        rd_val[`AADC_RX1_PERR]   = perr_flag;
        rd_val[`AADC_RX1_DETECT] = detect_flag;
      end
      `AADC_RX2_OFS >> 2: rd_val[1:0] = {bank_switching, bank_indication};
      `AADC_RY0_OFS >> 2: rd_val[15:0] = ry0;
      `AADC_RY1_OFS >> 2: rd_val[2:0] = param_cmd;
      `AADC_RY2_OFS >> 2: rd_val[1:0] = bank_cmd;
      `AADC_FAULT_ID_OFS >> 2: rd_val[15:0] = latest_fault_id_word;
      `AADC_ID_COUNT_OFS >> 2: rd_val[15:0] = connected_id_count_word;
      default: begin
        if (s_axi_araddr[11:6] == `AADC_IN_BASE >> 6)
          rd_val[15:0] = in_snap[rword*16 +: 16];
        else if (s_axi_araddr[11:6] == `AADC_OUT_BASE >> 6)
          rd_val[15:0] = out_words[rword*16 +: 16];
        else if (s_axi_araddr[11:9] == `AADC_LIST_BASE >> 9)
          // entries beyond the count read as zero
          rd_val[15:0] = ({9'h000, lidx} < connected_id_count_word) ? id_list[lidx] : 16'h0000;
        else
          rd_ok = 1'b0;
      end
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'b00;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_val;
        s_axi_rresp   <= rd_ok ? 2'b00 : 2'b10;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

// file: tb/aadc_checker.sv
// Purpose: port assertions for the detection controller
// Assumes: one clock, synchronous active-low reset
// Notes:   detection progress seen through store and probe lines
`timescale 1ns/1ps
`default_nettype none
module aadc_checker #(
  parameter [31:0] STORE_CYC = 32'h0000000a
) (
  input wire logic         aclk,
  input wire logic         aresetn,
  input wire logic         s_axi_bvalid,
  input wire logic         s_axi_bready,
  input wire logic [1:0]   s_axi_bresp,
  input wire logic         s_axi_arvalid,
  input wire logic         s_axi_arready,
  input wire logic         s_axi_rvalid,
  input wire logic         s_axi_rready,
  input wire logic [31:0]  s_axi_rdata,
  input wire logic [255:0] field_out,
  input wire logic         store_indicator,
  input wire logic         probe_req,
  input wire logic [15:0]  probe_id,
  input wire logic         probe_ack
);
  logic [31:0] lit_cnt;
  logic [15:0] next_id;
  default clocking dcb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // cycles the store indicator has been lit
  always_ff @(posedge aclk) begin
    if (!aresetn || !store_indicator) lit_cnt <= 32'h0;
    else lit_cnt <= lit_cnt + 32'h1;
  end
  // id expected at the next probe
  always_ff @(posedge aclk) begin
    if (!aresetn || store_indicator) next_id <= 16'h0;
    else if (probe_req && probe_ack) next_id <= next_id + 16'h1;
  end
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  a_store_length: assert property (
    $fell(store_indicator) |-> lit_cnt == STORE_CYC) else $error("store lit wrong time");
  a_settle_gap: assert property (
    $fell(store_indicator) |-> !probe_req [*8] ##[1:8] probe_req)
    else $error("probing not after settle");
  a_probe_order: assert property (
    $rose(probe_req) |-> probe_id == next_id) else $error("probe id out of order");
  a_probe_drop: assert property (probe_req && probe_ack |=> !probe_req)
    else $error("probe held after ack");
  a_probe_hold: assert property (probe_req && !probe_ack
    |=> probe_req && $stable(probe_id)) else $error("probe dropped early");
  a_out_frozen: assert property (
    store_indicator || (probe_req && !probe_ack) |=> $stable(field_out))
    else $error("outputs moved while detecting");
endmodule
bind aadc_top aadc_checker #(.STORE_CYC(STORE_CYC)) u_chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .field_out(field_out), .store_indicator(store_indicator), .probe_req(probe_req),
  .probe_id(probe_id), .probe_ack(probe_ack));
`default_nettype wire

// file: tb/aadc_field_model.sv
// Purpose: field side answering id probes
// Assumes: ids 1,3,5,7,9,11 good, 2 unset, 4 duplicated
// Notes:   result lines toggle outside the ack cycle
`timescale 1ns/1ps
`default_nettype none
module aadc_field_model (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [3:0]  slow,
  input  wire logic        probe_req,
  input  wire logic [15:0] probe_id,
  output logic             probe_ack,
  output logic             probe_found,
  output logic             probe_no_id,
  output logic             probe_dup
);
  logic [3:0] wait_cnt;
  logic       toggle;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      probe_ack <= 1'b0;
      wait_cnt <= 4'h0;
      toggle <= 1'b0;
    end else begin
      toggle <= !toggle;
      probe_ack <= probe_req && !probe_ack && wait_cnt >= slow;
      if (!probe_req || probe_ack) wait_cnt <= 4'h0;
      else wait_cnt <= wait_cnt + 4'h1;
    end
  end
  always_comb begin
    probe_found = toggle;
    probe_no_id = !toggle;
    probe_dup = toggle;
    if (probe_ack) begin
      // unset and duplicated ids still answer, so they count as found
      probe_found = (probe_id[0] || probe_id == 16'h0002 || probe_id == 16'h0004) &&
                    probe_id < 16'h000c;
      probe_no_id = probe_id == 16'h0002;
      probe_dup = probe_id == 16'h0004;
    end
  end
endmodule
`default_nettype wire

// file: tb/testbench.sv
// Purpose: self-checking bench of the detection controller
// Assumes: shortened counts; field model answers probes
// Notes:   registers reached through AXI4-Lite tasks
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic         aclk = 1'b0, aresetn = 1'b0, awv = 1'b0, wv = 1'b0, bry = 1'b0;
  logic         arv = 1'b0, rry = 1'b0, push = 1'b0, adj = 1'b0, pdone = 1'b1;
  logic         perr = 1'b0, pacc = 1'b1, bank = 1'b1, paccing = 1'b0, bsw = 1'b0;
  logic [3:0]   strb = 4'hf;
  logic         awr, wrdy, bv, arr, rv, led, preq, pack, pfnd, pnid, pdup;
  logic [1:0]   br, rr, bcmd, resp;
  logic [2:0]   flt = 3'h0, pcmd;
  logic [3:0]   slow = 4'h0;
  logic [11:0]  awa = 12'h0, ara = 12'h0;
  logic [15:0]  ecode = 16'h0, pid;
  logic [31:0]  wd = 32'h0, rdv, rdata;
  logic [255:0] fin, fout;
  int           failures = 0;
  int           comparisons = 0;
  always #4 aclk = ~aclk;
  aadc_top #(.STARTUP_CYC(32'h14), .STORE_CYC(32'ha), .SETTLE_CYC(32'ha),
    .PRESS_CYC(32'h8), .ID_LAST(16'h000f), .MAX_SLAVES(8'h04)) dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(strb),
    .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_bresp(br), .s_axi_bvalid(bv),
    .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arprot(3'h0), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rr), .s_axi_rvalid(rv),
    .s_axi_rready(rry), .push_switch(push), .field_short(flt[0]), .field_vdrop(flt[1]),
    .field_disc(flt[2]), .error_code(ecode), .adjust_active_flag(adj),
    .param_access_flag(pacc), .param_accessing_flag(paccing), .param_done(pdone),
    .param_err_event(perr), .bank_indication(bank), .bank_switching(bsw),
    .field_in(fin), .field_out(fout), .param_cmd(pcmd), .bank_cmd(bcmd),
    .store_indicator(led), .probe_req(preq), .probe_id(pid), .probe_ack(pack),
    .probe_found(pfnd), .probe_no_id(pnid), .probe_dup(pdup));
  aadc_field_model fm (.aclk(aclk), .aresetn(aresetn), .slow(slow), .probe_req(preq),
    .probe_id(pid), .probe_ack(pack), .probe_found(pfnd), .probe_no_id(pnid),
    .probe_dup(pdup));
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge aclk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    do begin
      @(posedge aclk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wrdy) wv <= 1'b0;
    end while (awv || wv);
    while (!bv) @(posedge aclk);
    resp = br;
    bry <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge aclk);
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    do @(posedge aclk); while (!arr);
    arv <= 1'b0;
    while (!rv) @(posedge aclk);
    rdv = rdata;
    resp = rr;
    rry <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
    comparisons++;
    if ((got & m) !== (exp & m)) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chkr(input logic [11:0] a, input logic [31:0] exp, input logic [31:0] m);
    rd(a);
    chk(rdv, exp, m);
  endtask
  // poll the detecting flag until it reaches v
  task automatic wait_det(input logic v);
    rdv = {27'h0, ~v, 4'h0};
    repeat (300) if (rdv[4] !== v) rd(12'h004);
    chk(rdv, {27'h0, v, 4'h0}, 32'h10);
  endtask
  task automatic print_verdict();
    $display("comparisons=%0d failures=%0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge aclk);
    failures++;
    print_verdict();
  end
  initial begin
    for (int k = 0; k < 16; k++) fin[16*k+:16] = {4'(k), 4'(15 - k), 8'h3c};
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 12; i++) begin
      @(posedge aclk);
      ecode <= (i > 0 && i < 5) ? 16'(i) + 16'h63 : (i > 4 && i < 7) ? 16'(i) + 16'hc3 : 16'h0;
      adj <= (i == 7);
      pdone <= (i != 8);
      flt <= (i > 8) ? 3'(4'h1 << (i - 9)) : 3'h0;
      repeat (2) @(posedge aclk);
      wr(12'h00c, 32'h2);
      repeat (4) @(posedge aclk);
      chkr(12'h004, 32'h0, 32'h10);
      if (i == 7) chkr(12'h000, 32'h8000, 32'h8000);
      if (i == 9) begin
        wr(12'h00c, 32'h1);
        wr(12'h00c, 32'h0);
        chkr(12'h000, 32'h2, 32'h3);
      end
      wr(12'h00c, 32'h0);
    end
    @(posedge aclk);
    flt <= 3'h0;
    wr(12'h00c, 32'h1);
    chkr(12'h000, 32'h0, 32'h1);
    wr(12'h00c, 32'h0);
    chkr(12'h000, 32'h1, 32'h1b);
    $display("test refusals done");
    chkr(12'h000, 32'h400, 32'hc00);
    chkr(12'h008, 32'h1, 32'h3);
    pacc <= 1'b0;
    paccing <= 1'b1;
    bank <= 1'b0;
    bsw <= 1'b1;
    chkr(12'h000, 32'h800, 32'hc00);
    chkr(12'h008, 32'h2, 32'h3);
    wr(12'h010, 32'h7);
    chk({29'h0, pcmd}, 32'h7, 32'h7);
    wr(12'h014, 32'h3);
    chk({30'h0, bcmd}, 32'h3, 32'h3);
    wr(12'h0bc, 32'h1234);
    // field_out follows the output word one edge later
    @(posedge aclk);
    chk({16'h0, fout[255:240]}, 32'h1234, 32'hffff);
    strb <= 4'h2;
    wr(12'h0bc, 32'h5678);
    strb <= 4'hf;
    chkr(12'h0bc, 32'h5634, 32'hffff);
    for (int k = 0; k < 16; k++) chkr(12'h040 + 12'(4 * k), {16'h0, fin[16*k+:16]}, 32'hffff);
    rd(12'h100);
    chk({30'h0, resp}, 32'h2, 32'h3);
    wr(12'h100, 32'h1);
    chk({30'h0, resp}, 32'h2, 32'h3);
    perr <= 1'b1;
    @(posedge aclk);
    perr <= 1'b0;
    chkr(12'h004, 32'h4, 32'h4);
    $display("test map done");
    wr(12'h00c, 32'h2);
    wait_det(1'b1);
    chk({31'h0, led}, 32'h1, 32'h1);
    wr(12'h00c, 32'h0);
    wr(12'h080, 32'hbeef);
    chk(fout[31:0], 32'h0, 32'hffff);
    wait_det(1'b0);
    chk(fout[31:0], 32'hbeef, 32'hffff);
    chkr(12'h01c, 32'h4, 32'hffff);
    for (int i = 0; i < 5; i++) chkr(12'h200 + 12'(4 * i), (i < 4) ? 32'(2 * i + 1) : 32'h0, 32'hffff);
    chkr(12'h018, 32'h4, 32'hffff);
    chkr(12'h000, 32'h40, 32'h41);
    chkr(12'h004, 32'h7, 32'h17);
    wr(12'h00c, 32'h1);
    chkr(12'h000, 32'h0, 32'h1);
    wr(12'h00c, 32'h0);
    chkr(12'h004, 32'h2, 32'h7);
    chkr(12'h000, 32'h1, 32'h1);
    $display("test command detection done");
    slow <= 4'h3;
    push <= 1'b1;
    repeat (40) if (!led) @(posedge aclk);
    chk({31'h0, led}, 32'h1, 32'h1);
    push <= 1'b0;
    wait_det(1'b0);
    chkr(12'h01c, 32'h4, 32'hffff);
    $display("test press detection done");
    print_verdict();
  end
endmodule
`default_nettype wire
